// ===== trp_pkg.sv
// constants and types shared by the transceiver reset and power-down controller
package trp_pkg;

  // channel count limits: the status word holds three level bits per channel from bit 8 up
  localparam int          TRP_NCH_DEF        = 4;
  localparam int          TRP_NCH_MAX        = 8;
  localparam int          TRP_CH_W           = 3;

  // register bus geometry
  localparam int          TRP_ADDR_W         = 8;
  localparam int          TRP_DATA_W         = 32;

  // register byte offsets
  localparam logic [7:0]  TRP_OFS_LOCK_DELAY = 8'h00;
  localparam logic [7:0]  TRP_OFS_STATUS     = 8'h04;
  localparam logic [7:0]  TRP_OFS_SHORT      = 8'h08;

  // reset values
  localparam logic [15:0] TRP_LOCK_DELAY_RST = 16'h0010;

  // status field positions
  localparam int          TRP_ST_LOCK_BIT    = 0;
  localparam int          TRP_ST_PD_BIT      = 1;
  localparam int          TRP_ST_PLLRST_BIT  = 2;
  localparam int          TRP_ST_CHAN_LSB    = 8;

  // least reset pulse width, in clock cycles
  localparam logic [1:0]  TRP_MIN_PULSE_CYC  = 2'h2;

  // per-channel reset request: tx digital in bit 0, rx digital in bit 1, rx analog in bit 2
  typedef struct packed
  {
    logic rx_ana;
    logic rx_dig;
    logic tx_dig;
  } trp_chan_rst_type;

endpackage : trp_pkg

// ===== trp_rst_sync.sv
// two-flop level synchroniser with asynchronous assertion of the held output
`timescale 1ns/100ps
`default_nettype none
module trp_rst_sync
  import trp_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // raw asynchronous levels
  input  wire logic [W-1:0] async_in,
  // synchronised level and asserted-at-once, released-late level
  output logic      [W-1:0] sync_out,
  output logic      [W-1:0] held_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds the second stage only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  // assertion passes straight through, release waits for the synchronised copy
  assign held_out = async_in | sync_q;
  assign sync_out = sync_q;

endmodule : trp_rst_sync
`default_nettype wire

// ===== trp_reset_ctrl.sv
// reset and power-down control for a block of transceiver channels
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - each channel has its own coding-sublayer and analog resets, independent of others
// - all resets and power-down act at once, without waiting for a clock edge
// - transmit digital reset clears all transmit coding logic including its state machine
// - receive digital reset clears receive coding logic, alignment machines and verifiers
// - receive analog reset resets that channel's clock-and-data-recovery unit
// - block power-down powers down coding and analog parts of every channel
// - block power-down is one shared input, independent of every reset input
// - PLL lock status goes high when the PLL is locked to its reference
// - block power-down leaves the reference clock input buffers powered
module trp_reset_ctrl
  import trp_pkg::*;
#(
  parameter int NCH = TRP_NCH_DEF
)
(
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  // register port
  input  wire logic [TRP_ADDR_W-1:0] ADDR,
  input  wire logic [TRP_DATA_W-1:0] WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [TRP_DATA_W-1:0] RDATA,
  // user reset and power-down requests
  input  wire trp_chan_rst_type [NCH-1:0] CH_RST_IN,
  input  wire logic                  PLL_RESET_IN,
  input  wire logic                  BLOCK_PWRDN_IN,
  // raw lock indication from the PLL
  input  wire logic                  PLL_LOCK_RAW,
  // resets and power-down toward the channel logic
  output logic      [NCH-1:0]        TX_PCS_RST,
  output logic      [NCH-1:0]        RX_PCS_RST,
  output logic      [NCH-1:0]        RX_CDR_RST,
  output logic      [NCH-1:0]        CH_PWRDN,
  output logic                       PLL_RST,
  output logic                       PLL_PWRDN,
  output logic                       REFCLK_BUF_EN,
  // lock status toward user logic
  output logic                       PLL_LOCKED
);

  localparam int NB = TRP_CH_W * NCH;
  localparam int SW = NB + 3;

  // refuse channel counts the status word cannot carry
  if (NCH < 1 || NCH > TRP_NCH_MAX)
  begin : g_bad_nch
    $error("trp_reset_ctrl: NCH out of range");
  end

  logic [SW-1:0] raw_all;
  logic [SW-1:0] sync_all;
  logic [SW-1:0] held_all;
  logic [NB-1:0] ch_sync_d1_q;
  logic [NB-1:0] short_q;
  logic [NB-1:0] short_set;
  logic [15:0]   lock_delay_q;
  logic [15:0]   lock_cnt_q;
  logic          lock_ok;
  logic          wr_short;

  // channel requests, then PLL reset, power-down and lock
  assign raw_all = {PLL_LOCK_RAW, BLOCK_PWRDN_IN, PLL_RESET_IN, CH_RST_IN};

  trp_rst_sync #(.W(SW)) u_sync
  (
    .clk      (CLK),
    .reset    (RESET),
    .async_in (raw_all),
    .sync_out (sync_all),
    .held_out (held_all)
  );

  // per-channel reset fan-out; each channel sees only its own requests
  for (genvar i = 0; i < NCH; i++)
  begin : g_chan
    assign TX_PCS_RST[i] = held_all[TRP_CH_W*i];
    assign RX_PCS_RST[i] = held_all[TRP_CH_W*i+1];
    assign RX_CDR_RST[i] = held_all[TRP_CH_W*i+2];
    // power-down reaches every channel but touches no reset
    assign CH_PWRDN[i]   = held_all[NB+1];

    tx_hold_a: assert property (@(posedge CLK) disable iff (RESET)
      $fell(CH_RST_IN[i].tx_dig) |=> TX_PCS_RST[i])
      else $error("transmit reset released before synchronised copy");
    rx_now_a: assert property (@(posedge CLK) disable iff (RESET)
      CH_RST_IN[i].rx_dig |-> RX_PCS_RST[i] ##1 (RX_PCS_RST[i] || !CH_RST_IN[i].rx_dig))
      else $error("receive reset not asserted at once");
    cdr_rst_a: assert property (@(posedge CLK) disable iff (RESET)
      $rose(CH_RST_IN[i].rx_ana) |-> RX_CDR_RST[i] ##2 RX_CDR_RST[i] || !CH_RST_IN[i].rx_ana)
      else $error("recovery reset dropped while requested");
    chan_indep_a: assert property (@(posedge CLK) disable iff (RESET)
      (!CH_RST_IN[i].tx_dig && !$past(CH_RST_IN[i].tx_dig, 1) && !$past(CH_RST_IN[i].tx_dig, 2)
       && !$past(CH_RST_IN[i].tx_dig, 3)) |-> !TX_PCS_RST[i])
      else $error("transmit reset asserted without its own request");
  end : g_chan

  // PLL reset and PLL power-down pass asynchronously too
  assign PLL_RST       = held_all[NB];
  assign PLL_PWRDN     = held_all[NB+1];
  // reference buffers stay up so the PLL can relock right after power-up
  assign REFCLK_BUF_EN = 1'b1;

  pd_all_a: assert property (@(posedge CLK) disable iff (RESET)
    BLOCK_PWRDN_IN |-> (&CH_PWRDN) && PLL_PWRDN)
    else $error("power-down missed a channel or the PLL");
  refclk_on_a: assert property (@(posedge CLK) disable iff (RESET)
    held_all[NB+1] |-> REFCLK_BUF_EN)
    else $error("reference buffers off during power-down");
  pll_rst_a: assert property (@(posedge CLK) disable iff (RESET)
    PLL_RESET_IN |-> PLL_RST)
    else $error("PLL reset not passed through");

  // delayed copy of the synchronised channel levels for release detection
  always_ff @(posedge CLK)
  begin
    if (RESET)
      ch_sync_d1_q <= '0;
    else
      ch_sync_d1_q <= sync_all[NB-1:0];
  end

  // pulse-width watch: a release after fewer than the least cycles sets a sticky flag
  for (genvar j = 0; j < NB; j++)
  begin : g_pulse
    logic [1:0] width_q;

    always_ff @(posedge CLK)
    begin
      if (RESET)
        width_q <= 2'h0;
      else if (!sync_all[j])
        width_q <= 2'h0;
      else if (width_q != 2'h3)
        width_q <= width_q + 2'h1;
    end

    // width_q still holds the high count in the cycle after the fall
    assign short_set[j] = ch_sync_d1_q[j] && !sync_all[j] && (width_q < TRP_MIN_PULSE_CYC);
  end : g_pulse

  assign wr_short = WR && (ADDR == TRP_OFS_SHORT);

  // short-pulse flags: write one to clear, a new event in the same cycle wins
  always_ff @(posedge CLK)
  begin
    if (RESET)
      short_q <= '0;
    else
      short_q <= (short_q & ~(wr_short ? WDATA[NB-1:0] : '0)) | short_set;
  end

  short_set_a: assert property (@(posedge CLK) disable iff (RESET)
    short_set[0] |=> short_q[0])
    else $error("short pulse flag lost against a clear");

  // lock delay register steers how long raw lock must hold
  always_ff @(posedge CLK)
  begin
    if (RESET)
      lock_delay_q <= TRP_LOCK_DELAY_RST;
    else if (WR && (ADDR == TRP_OFS_LOCK_DELAY))
      lock_delay_q <= WDATA[15:0];
  end

  // lock is trusted only with no PLL reset and no power-down pending
  assign lock_ok = sync_all[NB+2] && !sync_all[NB] && !sync_all[NB+1];

  // lock qualifier: synchronised lock must hold lock_delay_q + 1 cycles before status rises
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      lock_cnt_q <= 16'h0000;
      PLL_LOCKED <= 1'b0;
    end
    else if (!lock_ok)
    begin
      lock_cnt_q <= 16'h0000;
      PLL_LOCKED <= 1'b0;
    end
    else if (lock_cnt_q == lock_delay_q)
      PLL_LOCKED <= 1'b1;
    else
      lock_cnt_q <= lock_cnt_q + 16'h0001;
  end

  lock_cause_a: assert property (@(posedge CLK) disable iff (RESET)
    $rose(PLL_LOCKED) |-> $past(lock_ok, 1) && $past(lock_cnt_q == lock_delay_q, 1))
    else $error("lock status rose without qualified lock");
  lock_drop_a: assert property (@(posedge CLK) disable iff (RESET)
    (PLL_RESET_IN || BLOCK_PWRDN_IN) |-> ##[1:3] !PLL_LOCKED)
    else $error("lock status held through PLL reset");

  // read data stands in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
      RDATA <= '0;
    else if (RD)
    begin
      RDATA <= '0;
      unique case (ADDR)
        TRP_OFS_LOCK_DELAY: RDATA[15:0] <= lock_delay_q;
        TRP_OFS_STATUS:
        begin
          RDATA[TRP_ST_LOCK_BIT]                 <= PLL_LOCKED;
          RDATA[TRP_ST_PD_BIT]                   <= sync_all[NB+1];
          RDATA[TRP_ST_PLLRST_BIT]               <= sync_all[NB];
          RDATA[TRP_ST_CHAN_LSB +: NB]           <= sync_all[NB-1:0];
        end
        TRP_OFS_SHORT:      RDATA[NB-1:0] <= short_q;
        default:            RDATA <= '0;
      endcase
    end
    else
      RDATA <= '0;
  end

  cv_lock_c:  cover property (@(posedge CLK) disable iff (RESET) $rose(PLL_LOCKED));
  cv_pd_c:    cover property (@(posedge CLK) disable iff (RESET) $rose(BLOCK_PWRDN_IN));
  cv_short_c: cover property (@(posedge CLK) disable iff (RESET) |short_set);
  cv_tx_c:    cover property (@(posedge CLK) disable iff (RESET) $fell(TX_PCS_RST[0]));

endmodule : trp_reset_ctrl
`default_nettype wire

// ===== trp_user_model.sv
// user-side reset sequencer model driving the block's request inputs
`timescale 1ns/100ps
`default_nettype none
module trp_user_model
  import trp_pkg::*;
#(
  parameter int NCH = 4
)
(
  // clock, reset and commands
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  go,
  input  wire logic                  pll_en,
  input  wire logic [3:0]            hold,
  input  wire logic [NCH-1:0]        mask,
  input  wire logic                  locked,
  // requests toward the block
  output var trp_chan_rst_type [NCH-1:0] rst_req,
  output logic                       pll_req
);
  logic [3:0] cnt_q;

  // assert on go; pll and analog drop after the count, digital also waits for lock when pll_en is set
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q   <= 4'h0;
      pll_req <= 1'b0;
      rst_req <= '0;
    end
    else if (go)
    begin
      cnt_q   <= hold;
      pll_req <= pll_en; // pll_en with an empty mask stands for the reconfiguration pulse
      for (int i = 0; i < NCH; i++)
        rst_req[i] <= mask[i] ? 3'h7 : 3'h0;
    end
    else if (cnt_q > 4'h1)
      cnt_q <= cnt_q - 4'h1; // width in clocks, hold of 1 only when told
    else
    begin
      cnt_q   <= 4'h0;
      pll_req <= 1'b0; // released on an edge
      for (int i = 0; i < NCH; i++)
      begin
        rst_req[i].rx_ana <= 1'b0;
        if (locked || !pll_en)
        begin
          rst_req[i].rx_dig <= 1'b0; // clocks must be stable first
          rst_req[i].tx_dig <= 1'b0;
        end
      end
    end
  end
endmodule : trp_user_model
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the transceiver reset and power-down controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import trp_pkg::*;
  localparam int NCH = 4;
  logic CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, go = 1'b0, pll_en = 1'b0, rd_q = 1'b0;
  logic BLOCK_PWRDN_IN = 1'b0, PLL_LOCK_RAW = 1'b0, PLL_RESET_IN, PLL_RST, PLL_PWRDN, REFCLK_BUF_EN, PLL_LOCKED;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, rnd, exp_q[$];
  logic [3:0] hold = 4'h2, mask = 4'h0;
  logic [15:0] dly;
  logic [31:0] st_exp;
  logic [NCH-1:0] TX_PCS_RST, RX_PCS_RST, RX_CDR_RST, CH_PWRDN;
  trp_chan_rst_type [NCH-1:0] CH_RST_IN;
  int err_total = 0, check_count = 0, seed = 49637, n;

  // 20 MHz clock
  always #25 CLK = ~CLK;

  trp_reset_ctrl #(.NCH(NCH)) uut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CH_RST_IN(CH_RST_IN), .PLL_RESET_IN(PLL_RESET_IN), .BLOCK_PWRDN_IN(BLOCK_PWRDN_IN),
    .PLL_LOCK_RAW(PLL_LOCK_RAW), .TX_PCS_RST(TX_PCS_RST), .RX_PCS_RST(RX_PCS_RST), .RX_CDR_RST(RX_CDR_RST),
    .CH_PWRDN(CH_PWRDN), .PLL_RST(PLL_RST), .PLL_PWRDN(PLL_PWRDN), .REFCLK_BUF_EN(REFCLK_BUF_EN),
    .PLL_LOCKED(PLL_LOCKED));
  trp_user_model #(.NCH(NCH)) far (.clk(CLK), .rst(RESET), .go(go), .pll_en(pll_en), .hold(hold),
    .mask(mask), .locked(PLL_LOCKED), .rst_req(CH_RST_IN), .pll_req(PLL_RESET_IN));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr_reg

  // the expected read value is noted here and compared by the watcher below
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    exp_q.push_back(e);
    @(posedge CLK);
    RD <= 1'b0;
  endtask : rd_reg

  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask : cyc

  // commands one sequence of the far-side model
  task automatic seq(input logic p, input logic [3:0] h, input logic [3:0] m);
    @(posedge CLK);
    {go, pll_en, hold, mask} <= {1'b1, p, h, m};
    @(posedge CLK);
    go <= 1'b0;
    #1;
  endtask : seq

  task automatic wait_lock;
    n = 0;
    while (PLL_LOCKED !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_lock

  // read data stand only in the cycle after the strobe
  always @(posedge CLK)
  begin
    rd_q <= RD;
    if (rd_q)
      check("read data", RDATA, exp_q.pop_front());
    else if (!RESET && RDATA !== 32'h0)
      check("idle read data", RDATA, 32'h0);
  end

  // watchdog, far beyond the expected run
  initial
  begin
    #2000000;
    err_total++;
    stop_test();
  end

  initial
  begin
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    rd_reg(TRP_OFS_LOCK_DELAY, {16'h0, TRP_LOCK_DELAY_RST});
    rd_reg(8'h0c, 32'h0);
    rnd = $random(seed) & 32'hffff_0007 | 32'h8;
    dly = rnd[15:0];
    wr_reg(TRP_OFS_LOCK_DELAY, rnd);
    rd_reg(TRP_OFS_LOCK_DELAY, {16'h0, dly});
    @(posedge CLK);
    PLL_LOCK_RAW <= 1'b1;
    wait_lock();
    check("lock delay", n == dly + 3, 1);
    rd_reg(TRP_OFS_STATUS, 32'h1);
    $display("test registers and lock done");
    @(posedge CLK);
    BLOCK_PWRDN_IN <= 1'b1;
    #1;
    check("pd channels", CH_PWRDN, 4'hf);
    check("pd pll refclk rst", {PLL_PWRDN, REFCLK_BUF_EN, PLL_RST}, 3'h6);
    cyc(3);
    check("pd lock", PLL_LOCKED, 0);
    rd_reg(TRP_OFS_STATUS, 32'h2);
    @(posedge CLK);
    BLOCK_PWRDN_IN <= 1'b0;
    #1;
    check("pd held", CH_PWRDN, 4'hf);
    cyc(2);
    check("pd off", CH_PWRDN, 0);
    $display("test power-down done");
    seq(1'b1, 4'h4, 4'hf);
    check("seq pll", PLL_RST, 1);
    check("seq tx", TX_PCS_RST, 4'hf);
    cyc(3);
    check("seq unlock", PLL_LOCKED, 0);
    wait_lock();
    check("seq rx held", RX_PCS_RST, 4'hf);
    check("seq cdr free", RX_CDR_RST, 0);
    cyc(4);
    check("seq tx free", TX_PCS_RST, 0);
    $display("test sequence done");
    // a PLL reset pulse with no channel requests, as the reconfiguration controller gives it
    seq(1'b1, 4'h2, 4'h0);
    check("reconf pll", {PLL_RST, TX_PCS_RST, RX_CDR_RST}, {1'b1, 8'h00});
    cyc(2);
    rd_reg(TRP_OFS_STATUS, 32'h4);
    check("reconf unlock", PLL_LOCKED, 0);
    wait_lock();
    check("reconf relock", PLL_LOCKED, 1);
    $display("test PLL reconfiguration reset done");
    rnd = $random(seed);
    seq(1'b0, 4'h3, rnd[3:0] | 4'h1);
    check("chan tx", TX_PCS_RST, mask);
    check("chan rx", {RX_PCS_RST, RX_CDR_RST}, {mask, mask});
    // status shows only the requested channels once their copies are synchronised
    st_exp = 32'h1;
    for (int i = 0; i < NCH; i++)
      if (mask[i])
        st_exp[TRP_ST_CHAN_LSB + TRP_CH_W * i +: TRP_CH_W] = 3'h7;
    cyc(1);
    rd_reg(TRP_OFS_STATUS, st_exp);
    cyc(6);
    rd_reg(TRP_OFS_SHORT, 32'h0);
    seq(1'b0, 4'h1, 4'h4);
    cyc(6);
    rd_reg(TRP_OFS_SHORT, 32'h7 << 6);
    wr_reg(TRP_OFS_SHORT, 32'h7 << 6);
    rd_reg(TRP_OFS_SHORT, 32'h0);
    $display("test channels and short pulses done");
    cyc(3);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
